// ---- hdl/pasd_cfg.svh ----
`ifndef PASD_CFG_SVH
`define PASD_CFG_SVH

// Program address layout
`define PASD_AW 32
`define PASD_BIT_TOP 31
`define PASD_BIT_HI 30
`define PASD_BIT_WIN 29

// Translation constants
`define PASD_USER_OFFSET 32'h4000_0000
`define PASD_WIN_MASK 32'h1fff_ffff
`define PASD_RESET_VECTOR 32'hbfc0_0000
`define PASD_BOOT_PHYS 32'h1fc0_0000

// Reset values
`define PASD_RST_USER 1'b0
`define PASD_RST_ADDR 32'h0000_0000

`endif

// ---- hdl/pasd_pkg.sv ----
`include "pasd_cfg.svh"

package pasd_pkg;

  typedef enum logic [3:0] {
    seg_user = 4'b0001,
    seg_cached = 4'b0010,
    seg_uncached = 4'b0100,
    seg_konly = 4'b1000
  } pasd_seg_e;

  typedef enum logic [1:0] {
    st_boot = 2'b01,
    st_run = 2'b10
  } pasd_state_e;

  typedef enum logic [1:0] {
    cause_none = 2'h0,
    cause_addr = 2'h1,
    cause_priv = 2'h2
  } pasd_cause_e;

  typedef struct packed {
    pasd_state_e fsm;
    logic user;
    pasd_cause_e cause;
    logic bad_fetch;
    logic [`PASD_AW-1:0] bad_addr;
  } pasd_state_s;

  function automatic pasd_seg_e pasd_seg_of(input logic [`PASD_AW-1:0] a);
    pasd_seg_e s;
    if (!a[`PASD_BIT_TOP]) begin
      s = seg_user;
    end else if (a[`PASD_BIT_HI]) begin
      s = seg_konly;
    end else if (a[`PASD_BIT_WIN]) begin
      s = seg_uncached;
    end else begin
      s = seg_cached;
    end
    return s;
  endfunction : pasd_seg_of

endpackage : pasd_pkg

// ---- hdl/pasd_xlat_if.sv ----
`timescale 1ns/10ps
`include "pasd_cfg.svh"

interface pasd_xlat_if;
  import pasd_pkg::*;
  logic [`PASD_AW-1:0] prog_addr;
  logic user_mode;
  logic [`PASD_AW-1:0] phys_addr;
  logic cacheable;
  logic addr_trap;
  pasd_seg_e seg;

  modport requester (
    output prog_addr,
    output user_mode,
    input phys_addr,
    input cacheable,
    input addr_trap,
    input seg
  );

  modport decoder (
    input prog_addr,
    input user_mode,
    output phys_addr,
    output cacheable,
    output addr_trap,
    output seg
  );
endinterface : pasd_xlat_if

// ---- hdl/pasd_seg_decode.sv ----
`timescale 1ns/10ps
`include "pasd_cfg.svh"

module pasd_seg_decode
  import pasd_pkg::*;
(
  pasd_xlat_if.decoder xl
);

  pasd_seg_e seg;
  logic [`PASD_AW-1:0] phys;
  logic cach;
  logic trap;

  always_comb begin
    seg = pasd_seg_of(xl.prog_addr);
    phys = xl.prog_addr;
    cach = 1'b1;
    unique case (seg)
      seg_user: begin
        // Carry out of the top bit is dropped on purpose
        phys = `PASD_AW'(xl.prog_addr + `PASD_USER_OFFSET);
        cach = 1'b1;
      end
      seg_cached: begin
        phys = xl.prog_addr & `PASD_WIN_MASK;
        cach = 1'b1;
      end
      seg_uncached: begin
        phys = xl.prog_addr & `PASD_WIN_MASK;
        cach = 1'b0;
      end
      seg_konly: begin
        phys = xl.prog_addr;
        cach = 1'b1;
      end
    endcase
    // Any address with the top bit set is kernel only
    trap = xl.user_mode & xl.prog_addr[`PASD_BIT_TOP];
  end

  assign xl.seg = seg;
  assign xl.phys_addr = phys;
  assign xl.cacheable = cach;
  assign xl.addr_trap = trap;

endmodule : pasd_seg_decode

// ---- hdl/pasd_top.sv ----
// What this block does
// - Only addresses below two gigabytes are legal in user mode.
// - User segment addresses get one gigabyte added to form the physical address.
// - Cached kernel window drops the top bit, mapping onto lowest 512 megabytes.
// - Every access through the cached kernel window is marked cacheable.
// - Uncached kernel window drops the top three bits, aliasing lowest 512 megabytes.
// - Every access through the uncached kernel window is marked uncacheable.
// - After reset fetching starts at the reset vector, translated to boot location.
// - The upper one gigabyte segment is reachable only in kernel mode.
// - Upper segment addresses pass through untranslated as physical addresses.
// - In user mode any address with bit 31 set traps.
// - Reset enters kernel mode, where every segment is reachable without trap.
// - Privileged instructions executed in user mode trap.
// - System control coprocessor accesses count as privileged instructions.
`timescale 1ns/10ps
`include "pasd_cfg.svh"

module pasd_top
  import pasd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic acc_valid,
  input wire logic [`PASD_AW-1:0] acc_addr,
  input wire logic acc_fetch,
  input wire logic instr_valid,
  input wire logic instr_priv,
  input wire logic instr_cop,
  input wire logic mode_wr,
  input wire logic mode_wr_user,
  output logic boot_fetch,
  output logic [`PASD_AW-1:0] boot_addr,
  output logic [`PASD_AW-1:0] phys_addr,
  output logic cacheable,
  output logic [3:0] seg_sel,
  output logic addr_trap,
  output logic priv_trap,
  output logic user_mode,
  output logic [1:0] trap_cause,
  output logic [`PASD_AW-1:0] trap_addr,
  output logic trap_fetch
);

  pasd_state_s st_ff;
  pasd_state_s nxt_st;

  pasd_xlat_if xl ();

  logic booting;
  logic run_acc;
  logic cop_or_priv;

  pasd_seg_decode u_dec (
    .xl(xl.decoder)
  );

  assign booting = (st_ff.fsm == st_boot);
  assign run_acc = acc_valid & ~booting;
  assign cop_or_priv = instr_priv | instr_cop;

  // Boot cycle steers the reset vector into the decoder
  assign xl.prog_addr = booting ? `PASD_RESET_VECTOR : acc_addr;
  assign xl.user_mode = st_ff.user & ~booting;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.fsm)
      st_boot: begin
        nxt_st.fsm = st_run;
      end
      st_run: begin
        nxt_st.fsm = st_run;
      end
    endcase
    if (mode_wr && !booting) begin
      nxt_st.user = mode_wr_user;
    end
    // A trap always returns the core to kernel mode, over any mode write
    if (run_acc && xl.addr_trap) begin
      nxt_st.user = 1'b0;
      nxt_st.cause = cause_addr;
      nxt_st.bad_addr = acc_addr;
      nxt_st.bad_fetch = acc_fetch;
    end else if (priv_trap) begin
      nxt_st.user = 1'b0;
      nxt_st.cause = cause_priv;
      nxt_st.bad_addr = `PASD_RST_ADDR;
      nxt_st.bad_fetch = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.fsm <= st_boot;
      st_ff.user <= `PASD_RST_USER;
      st_ff.cause <= cause_none;
      st_ff.bad_fetch <= 1'b0;
      st_ff.bad_addr <= `PASD_RST_ADDR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign boot_fetch = booting;
  assign boot_addr = `PASD_RESET_VECTOR;
  assign phys_addr = xl.phys_addr;
  assign cacheable = xl.cacheable;
  assign seg_sel = xl.seg;
  assign addr_trap = run_acc & xl.addr_trap;
  assign priv_trap = instr_valid & ~booting & st_ff.user & cop_or_priv;
  assign user_mode = st_ff.user;
  assign trap_cause = st_ff.cause;
  assign trap_addr = st_ff.bad_addr;
  assign trap_fetch = st_ff.bad_fetch;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_user_legal_low: assert property (
    run_acc && user_mode && !acc_addr[`PASD_BIT_TOP] |-> !addr_trap
  ) else $error("user access below 2G trapped");

  a_user_offset_add: assert property (
    run_acc && !acc_addr[`PASD_BIT_TOP]
      |-> phys_addr == acc_addr + `PASD_USER_OFFSET && seg_sel == seg_user
  ) else $error("user segment offset wrong");

  a_cached_win_map: assert property (
    run_acc && acc_addr[31:29] == 3'h4
      |-> phys_addr == {3'h0, acc_addr[28:0]}
  ) else $error("cached window translation wrong");

  a_cached_win_attr: assert property (
    run_acc && seg_sel == seg_cached |-> cacheable && !addr_trap == !user_mode
  ) else $error("cached window attribute wrong");

  a_uncached_win_map: assert property (
    run_acc && acc_addr[31:29] == 3'h5
      |-> phys_addr == {3'h0, acc_addr[28:0]}
  ) else $error("uncached window translation wrong");

  a_uncached_attr: assert property (
    run_acc && acc_addr[31:29] == 3'h5 |-> !cacheable
  ) else $error("uncached window marked cacheable");

  a_boot_vector_once: assert property (
    boot_fetch |-> phys_addr == `PASD_BOOT_PHYS && !cacheable && !user_mode
      ##1 !boot_fetch [*3]
  ) else $error("boot fetch wrong");

  a_top_kernel_only: assert property (
    run_acc && acc_addr[31:30] == 2'h3 |-> addr_trap == user_mode
  ) else $error("upper segment privilege wrong");

  a_top_pass_through: assert property (
    run_acc && acc_addr[31:30] == 2'h3 |-> phys_addr == acc_addr && seg_sel == seg_konly
  ) else $error("upper segment not passed through");

  a_user_high_trap: assert property (
    run_acc && user_mode && acc_addr[`PASD_BIT_TOP]
      |-> addr_trap ##1 !user_mode && trap_cause == cause_addr && trap_addr == $past(acc_addr)
  ) else $error("user high address did not trap");

  a_kernel_no_trap: assert property (
    !user_mode |-> !addr_trap && !priv_trap
  ) else $error("kernel mode trapped");

  // Address trap in the same cycle takes the capture registers
  a_priv_instr_trap: assert property (
    instr_valid && !boot_fetch && user_mode && instr_priv
      |-> priv_trap ##1 !user_mode && trap_cause == ($past(addr_trap) ? cause_addr : cause_priv)
  ) else $error("privileged instruction did not trap");

  a_cop_instr_trap: assert property (
    instr_valid && !boot_fetch && user_mode && instr_cop |-> priv_trap
  ) else $error("coprocessor access did not trap");

  a_seg_same_cycle: assert property (
    run_acc |-> seg_sel == {acc_addr[31] & acc_addr[30], acc_addr[31] & ~acc_addr[30] & acc_addr[29],
      acc_addr[31] & ~acc_addr[30] & ~acc_addr[29], ~acc_addr[31]}
  ) else $error("segment select mismatch");

  a_boot_no_trap: assert property (
    boot_fetch |-> !addr_trap && !priv_trap && seg_sel == seg_uncached
  ) else $error("boot cycle not clean");

  a_trap_capture_kept: assert property (
    addr_trap |=> trap_fetch == $past(acc_fetch) && trap_addr == $past(acc_addr)
  ) else $error("trap capture wrong");

  c_user_trap: cover property (run_acc && addr_trap ##1 !user_mode);
  c_priv_trap: cover property (priv_trap);
  c_boot_then_run: cover property (boot_fetch ##1 run_acc && seg_sel == seg_cached);
  c_user_enter: cover property (mode_wr && mode_wr_user ##1 user_mode);

endmodule : pasd_top

// ---- testbench/pasd_pipe_model.sv ----
`timescale 1ns/10ps
`include "pasd_cfg.svh"

module pasd_pipe_model (
  input wire logic sys_clk,
  output logic acc_valid,
  output logic [`PASD_AW-1:0] acc_addr,
  output logic acc_fetch,
  output logic instr_valid,
  output logic instr_priv,
  output logic instr_cop,
  output logic mode_wr,
  output logic mode_wr_user
);
  initial begin
    {acc_valid, acc_fetch, instr_valid, instr_priv, instr_cop, mode_wr, mode_wr_user} = 7'h00;
    acc_addr = 32'h5a5a_a5a5;
  end

  // One cycle of pipeline activity, launched after a falling edge
  task automatic drive(input logic av, input logic [31:0] a, input logic f, input logic iv,
                       input logic ip, input logic ic, input logic mw, input logic mu);
    @(negedge sys_clk);
    acc_valid = av;
    // Address no longer meaningful when not valid
    acc_addr = av ? a : ~acc_addr;
    acc_fetch = f;
    instr_valid = iv;
    instr_priv = ip;
    instr_cop = ic;
    mode_wr = mw;
    mode_wr_user = mu;
  endtask : drive
endmodule : pasd_pipe_model

// ---- testbench/program_address_segment_decoder_tb_top.sv ----
`timescale 1ns/10ps
`include "pasd_cfg.svh"

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end

module program_address_segment_decoder_tb_top;
  logic sys_clk, rstn, av, af, iv, ip, ic, mw, mu, boot_fetch, cacheable;
  logic addr_trap, priv_trap, user_mode, trap_fetch;
  logic [31:0] aa, boot_addr, phys_addr, trap_addr, a;
  logic [3:0] seg_sel;
  logic [1:0] trap_cause;
  int failures = 0;
  int checks_done = 0;
  logic [1:0] cause_m = 2'h0;
  logic [31:0] tbl[$] = '{32'h0, 32'h7fff_ffff, 32'h8000_0000, 32'h9fff_ffff,
    32'ha000_0000, 32'hbfff_ffff, 32'hc000_0000, 32'hffff_ffff, 32'hbfc0_0000};

  pasd_pipe_model P (.sys_clk(sys_clk), .acc_valid(av), .acc_addr(aa), .acc_fetch(af),
    .instr_valid(iv), .instr_priv(ip), .instr_cop(ic), .mode_wr(mw), .mode_wr_user(mu));
  pasd_top DUT (.sys_clk(sys_clk), .rstn(rstn), .acc_valid(av), .acc_addr(aa), .acc_fetch(af),
    .instr_valid(iv), .instr_priv(ip), .instr_cop(ic), .mode_wr(mw), .mode_wr_user(mu),
    .boot_fetch(boot_fetch), .boot_addr(boot_addr), .phys_addr(phys_addr),
    .cacheable(cacheable), .seg_sel(seg_sel), .addr_trap(addr_trap), .priv_trap(priv_trap),
    .user_mode(user_mode), .trap_cause(trap_cause), .trap_addr(trap_addr),
    .trap_fetch(trap_fetch));

  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic set_mode(input logic u);
    P.drive(0, 0, 0, 0, 0, 0, 1, u);
    @(posedge sys_clk);
    #1;
    `CHK(user_mode, u)
  endtask : set_mode

  // Access in given mode, checked against the segment model
  task automatic acc(input logic [31:0] x, input logic f, input logic u);
    logic [31:0] ep;
    logic [3:0] es;
    es = !x[31] ? 4'h1 : x[30] ? 4'h8 : x[29] ? 4'h4 : 4'h2;
    ep = !x[31] ? x + 32'h4000_0000 : x[30] ? x : x & 32'h1fff_ffff;
    P.drive(1, x, f, 0, 0, 0, 0, 0);
    #1;
    `CHK(seg_sel, es)
    `CHK(phys_addr, ep)
    if (es != 4'h8) `CHK(cacheable, es != 4'h4)
    `CHK(addr_trap, u & x[31])
    if (u && x[31]) begin
      @(posedge sys_clk);
      #1;
      cause_m = 2'h1;
      `CHK(user_mode, 1'b0)
      `CHK(trap_cause, 2'h1)
      `CHK(trap_addr, x)
      `CHK(trap_fetch, f)
    end
  endtask : acc

  initial begin
    rstn = 0;
    void'($urandom(88));
    repeat (12) @(negedge sys_clk);
    `CHK(boot_fetch, 1'b1)
    `CHK(boot_addr, 32'hbfc0_0000)
    `CHK(phys_addr, 32'h1fc0_0000)
    `CHK(seg_sel, 4'h4)
    `CHK(cacheable, 1'b0)
    `CHK(user_mode, 1'b0)
    rstn = 1;
    @(posedge sys_clk);
    #1;
    `CHK(boot_fetch, 1'b0)
    for (int i = 0; i < 40; i++) tbl.push_back($urandom);
    foreach (tbl[i]) acc(tbl[i], $urandom_range(1, 0), 0);
    foreach (tbl[i]) begin
      set_mode(1);
      acc(tbl[i], $urandom_range(1, 0), 1);
    end
    for (int k = 0; k < 8; k++) begin
      set_mode(k[2]);
      a = {1'b1, 31'($urandom)};
      P.drive(k[0], a, 0, 1, k[1], !k[1], 0, 0);
      #1;
      `CHK(priv_trap, k[2])
      `CHK(addr_trap, k[2] & k[0])
      @(posedge sys_clk);
      #1;
      // Address trap wins the capture over a privileged one
      if (k[2]) cause_m = k[0] ? 2'h1 : 2'h2;
      `CHK(trap_cause, cause_m)
      `CHK(user_mode, 1'b0)
      if (k[2]) `CHK(trap_addr, k[0] ? a : 32'h0)
    end
    // Reset in mid-run from user mode, mode write left standing
    set_mode(1);
    @(negedge sys_clk);
    rstn = 0;
    #1;
    `CHK(user_mode, 1'b0)
    `CHK(boot_fetch, 1'b1)
    repeat (2) @(negedge sys_clk);
    rstn = 1;
    cause_m = 2'h0;
    @(posedge sys_clk);
    #1;
    `CHK(user_mode, 1'b0)
    `CHK(boot_fetch, 1'b0)
    P.drive(0, 0, 0, 0, 0, 0, 0, 0);
    test_done();
  end

  initial begin
    #2ms;
    failures++;
    test_done();
  end
endmodule : program_address_segment_decoder_tb_top
